//--- hw/uesc_top.v
// error flags, transfer status fifo and link control register block
// Function
// RL1: device mode token crc5 failure sets bit 1
// RL2: host mode frame-end error sets bit 1
// RL3: pid check failure sets bit 0
// RL4: late grant or truncation sets memory error
// RL5: turnaround timeout after 16 idle bit times
// RL6: eight enables match eight error flag positions
// RL7: enable bit 1 follows bit 1 dual meaning
// RL8: interrupt needs error summary enable too
// RL9: status bits 7-4 hold last endpoint
// RL10: status bit 3 one for transmit
// RL11: status bit 2 one for odd bank
// RL12: status shows four-entry fifo head, clear advances
// RL13: status bits 1-0 and upper read zero
// RL14: read-only bit shows j state seen
// RL15: control bit 6 shows live se0
// RL16: device hold bit set on setup, stalls
// RL17: host bit 5 shows token in progress
// RL18: software checks token busy before next token
// RL19: host drives bus reset while bit 4
// RL20: host enable change resets host logic
// RL21: resume drive; host appends low-speed eop
// RL22: software holds resume 10 or 25 ms
// RL23: error flags clear by writing one
// RL24: only enabled errors set summary flag
// RL25: host sends frame marker every 1 ms
// RL26: bank pointer reset returns banks to even
//
// Implementation choices: the placing of the registers and the plain strobed port.
`default_nettype none
`include "uesc_defines.vh"

module uesc_top #(
  parameter FIFO_DEPTH = 4,
  parameter FRAME_CYC = `UESC_FRAME_CYC,
  parameter TURN_CYC = `UESC_TURN_CYC
) (
  input wire I_CLK,
  input wire I_RST,
  input wire I_CE,
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  input wire I_DP,
  input wire I_DM,
  input wire I_PID_FAIL,
  input wire I_TOKEN_CRC_FAIL,
  input wire I_DATA_CRC_FAIL,
  input wire I_PARTIAL_BYTE,
  input wire I_BIT_STUFF_FAIL,
  input wire I_BUS_MATRIX_FAIL,
  input wire I_GRANT_LATE,
  input wire I_BUF_TRUNC,
  input wire I_EOP_AWAIT,
  input wire I_RESP_START,
  input wire I_XFER_ACTIVE,
  input wire I_SETUP_RX,
  input wire I_TOKEN_BUSY,
  input wire I_XFER_DONE,
  input wire [3:0] I_XFER_EP,
  input wire I_XFER_TX,
  input wire I_XFER_ODD,
  input wire I_DONE_CLR,
  input wire I_ERR_SUM_EN,
  output reg O_ERR_SUMMARY,
  output reg O_IRQ,
  output reg O_XFER_DONE,
  output reg O_STAT_FULL,
  output reg O_PKT_HOLD,
  output reg O_BUS_RESET_DRIVE,
  output reg O_HOST_LOGIC_RST,
  output reg O_RESUME_DRIVE,
  output reg O_LS_EOP,
  output reg O_BANK_RST,
  output reg O_MODULE_EN,
  output reg O_HOST_MODE,
  output reg O_SOF_SEND
);

  localparam PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // line pins are asynchronous to the clock
  wire dp_line;
  wire dm_line;
  uesc_sync2 u_sync_dp (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_d(I_DP),
    .o_q(dp_line)
  );
  uesc_sync2 u_sync_dm (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_d(I_DM),
    .o_q(dm_line)
  );
  wire j_line_state_seen = dp_line & ~dm_line; // [RL14]
  wire se0_seen = ~dp_line & ~dm_line; // [RL15]

  wire [7:0] err_flags_q;
  reg [7:0] err_en_q;
  reg [5:0] ctrl_q; // bits 5..0 of the control word, bit 5 is the hold bit
  wire host_role_enable = ctrl_q[`UESC_CON_HOST];
  wire wr_flags = I_WR & (I_ADDR == `UESC_OFS_ERR_FLAGS);
  wire wr_en = I_WR & (I_ADDR == `UESC_OFS_ERR_EN);
  wire wr_ctrl = I_WR & (I_ADDR == `UESC_OFS_CONTROL);
  wire host_toggle = wr_ctrl & (I_WDATA[`UESC_CON_HOST] != host_role_enable);

  // frame marker down-counter, host side only
  reg [31:0] frame_cnt_q;
  wire frame_zero = (frame_cnt_q == 32'h0000_0000);
  wire sof_run = host_role_enable & ctrl_q[`UESC_CON_ENABLE];
  always @(posedge I_CLK) begin
    if (I_RST) begin
      frame_cnt_q <= `UESC_RST_WORD;
      O_SOF_SEND <= 1'b0;
    end else if (I_CE) begin
      O_SOF_SEND <= 1'b0;
      if (host_toggle | ~sof_run) begin // [RL20]
        frame_cnt_q <= FRAME_CYC - 1;
      end else if (frame_zero) begin
        frame_cnt_q <= FRAME_CYC - 1; // [RL25]
        O_SOF_SEND <= 1'b1; // [RL25]
      end else begin
        frame_cnt_q <= frame_cnt_q - 32'h0000_0001;
      end
    end
  end

  // turnaround watch: idle bit times since an end-of-packet awaiting a reply
  reg turn_wait_q;
  reg [15:0] turn_cnt_q;
  reg turn_hit;
  always @(posedge I_CLK) begin
    if (I_RST) begin
      turn_wait_q <= 1'b0;
      turn_cnt_q <= 16'h0000;
    end else if (I_CE) begin
      if (I_EOP_AWAIT) begin
        turn_wait_q <= 1'b1;
        turn_cnt_q <= 16'h0000;
      end else if (I_RESP_START | turn_hit) begin
        turn_wait_q <= 1'b0;
      end else if (turn_wait_q) begin
        turn_cnt_q <= turn_cnt_q + 16'h0001;
      end
    end
  end
  always @* begin
    turn_hit = turn_wait_q & ~I_RESP_START & (turn_cnt_q == TURN_CYC - 1); // [RL5]
  end

  // hardware set events for each flag
  reg [7:0] err_set;
  always @* begin
    err_set = 8'h00;
    err_set[`UESC_ERR_PID] = I_PID_FAIL; // [RL3]
    err_set[`UESC_ERR_TOKEN] = host_role_enable ?
      (frame_zero & sof_run & I_XFER_ACTIVE) : I_TOKEN_CRC_FAIL; // [RL1] [RL2]
    err_set[`UESC_ERR_DATA_CRC] = I_DATA_CRC_FAIL;
    err_set[`UESC_ERR_PARTIAL] = I_PARTIAL_BYTE;
    err_set[`UESC_ERR_TURN] = turn_hit; // [RL5]
    err_set[`UESC_ERR_MEM] = I_GRANT_LATE | I_BUF_TRUNC; // [RL4]
    err_set[`UESC_ERR_BUSMX] = I_BUS_MATRIX_FAIL;
    err_set[`UESC_ERR_STUFF] = I_BIT_STUFF_FAIL;
  end

  wire [7:0] err_clr = wr_flags ? I_WDATA[7:0] : 8'h00;
  genvar fi;
  generate
    for (fi = 0; fi < 8; fi = fi + 1) begin : g_flag
      uesc_flag_bit u_flag (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_set(err_set[fi]),
        .i_clr(err_clr[fi]), // [RL23]
        .o_flag(err_flags_q[fi])
      );
    end
  endgenerate

  always @(posedge I_CLK) begin
    if (I_RST) begin
      err_en_q <= `UESC_RST_BYTE;
    end else if (I_CE & wr_en) begin
      err_en_q <= I_WDATA[7:0]; // [RL6]
    end
  end

  // summary and interrupt request
  wire err_pending = |(err_flags_q & err_en_q); // [RL6] [RL7] [RL24]
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_ERR_SUMMARY <= 1'b0;
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      O_ERR_SUMMARY <= err_pending; // [RL24]
      O_IRQ <= err_pending & I_ERR_SUM_EN; // [RL8]
    end
  end

  // transfer status fifo
  reg [5:0] stat_mem [0:FIFO_DEPTH-1];
  wire [PW-1:0] rd_ptr_q;
  wire [PW-1:0] wr_ptr_q;
  reg [PW:0] count_q;
  localparam [PW:0] DEPTH_W = FIFO_DEPTH;
  wire fifo_empty = (count_q == {(PW+1){1'b0}});
  wire fifo_full = (count_q == DEPTH_W);
  wire push = I_XFER_DONE & ~fifo_full;
  wire pop = I_DONE_CLR & ~fifo_empty; // [RL12]
  wire [5:0] head = stat_mem[rd_ptr_q];
  always @(posedge I_CLK) begin
    if (I_CE & push) begin
      stat_mem[wr_ptr_q] <= {I_XFER_EP, I_XFER_TX, I_XFER_ODD}; // [RL9] [RL10] [RL11]
    end
  end
  uesc_ring_ptr #(
    .DEPTH(FIFO_DEPTH),
    .PW(PW)
  ) u_wr_ptr (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_step(push),
    .o_ptr(wr_ptr_q)
  );
  uesc_ring_ptr #(
    .DEPTH(FIFO_DEPTH),
    .PW(PW)
  ) u_rd_ptr (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_step(pop), // [RL12]
    .o_ptr(rd_ptr_q)
  );
  always @(posedge I_CLK) begin
    if (I_RST) begin
      count_q <= {(PW+1){1'b0}};
      O_XFER_DONE <= 1'b0;
      O_STAT_FULL <= 1'b0;
    end else if (I_CE) begin
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
        O_XFER_DONE <= 1'b1;
        O_STAT_FULL <= (count_q == FIFO_DEPTH - 1);
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
        O_XFER_DONE <= (count_q != 1);
        O_STAT_FULL <= 1'b0;
      end
    end
  end

  // control register and its side effects
  reg resume_prev_q;
  always @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_q <= 6'h00;
      resume_prev_q <= 1'b0;
      O_PKT_HOLD <= 1'b0;
      O_BUS_RESET_DRIVE <= 1'b0;
      O_HOST_LOGIC_RST <= 1'b0;
      O_RESUME_DRIVE <= 1'b0;
      O_LS_EOP <= 1'b0;
      O_BANK_RST <= 1'b0;
      O_MODULE_EN <= 1'b0;
      O_HOST_MODE <= 1'b0;
    end else if (I_CE) begin
      if (wr_ctrl) begin
        ctrl_q[4:0] <= I_WDATA[4:0];
        if (host_toggle) begin
          ctrl_q[`UESC_CON_BUSRST] <= 1'b0; // [RL20]
        end
      end
      // hold bit: setup sets it, software clears it, set wins
      if (~host_role_enable & I_SETUP_RX) begin
        ctrl_q[`UESC_CON_HOLD] <= 1'b1; // [RL16]
      end else if (wr_ctrl) begin
        ctrl_q[`UESC_CON_HOLD] <= I_WDATA[`UESC_CON_HOLD] & ctrl_q[`UESC_CON_HOLD]; // [RL16]
      end
      resume_prev_q <= ctrl_q[`UESC_CON_RESUME];
      O_PKT_HOLD <= ~host_role_enable &
        (ctrl_q[`UESC_CON_HOLD] | I_SETUP_RX); // [RL16]
      O_BUS_RESET_DRIVE <= host_role_enable & ctrl_q[`UESC_CON_BUSRST]; // [RL19]
      O_HOST_LOGIC_RST <= host_toggle; // [RL20]
      O_RESUME_DRIVE <= ctrl_q[`UESC_CON_RESUME]; // [RL21]
      O_LS_EOP <= host_role_enable & resume_prev_q & ~ctrl_q[`UESC_CON_RESUME]; // [RL21]
      O_BANK_RST <= ctrl_q[`UESC_CON_BANKRST]; // [RL26]
      O_MODULE_EN <= ~host_role_enable & ctrl_q[`UESC_CON_ENABLE];
      O_HOST_MODE <= host_role_enable;
    end
  end

  // register read port, data one cycle after the strobe
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (I_ADDR == `UESC_OFS_ERR_FLAGS) begin
      rd_byte = err_flags_q;
    end else if (I_ADDR == `UESC_OFS_ERR_EN) begin
      rd_byte = err_en_q;
    end else if (I_ADDR == `UESC_OFS_STATUS) begin
      rd_byte = {head, 2'b00}; // [RL9] [RL10] [RL11] [RL13]
    end else if (I_ADDR == `UESC_OFS_CONTROL) begin
      rd_byte = {j_line_state_seen, se0_seen, // [RL14] [RL15]
        host_role_enable ? I_TOKEN_BUSY : ctrl_q[`UESC_CON_HOLD], // [RL17]
        ctrl_q[4:0]};
    end
  end
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= `UESC_RST_WORD;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? {24'h00_0000, rd_byte} : `UESC_RST_WORD; // [RL13]
    end
  end

endmodule // uesc_top

// two-stage synchroniser for one asynchronous line
module uesc_sync2 (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_d,
  output reg o_q
);

  reg s1_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      o_q <= 1'b0;
    end else if (i_ce) begin
      s1_q <= i_d;
      o_q <= s1_q;
    end
  end

endmodule // uesc_sync2

// one error flag: hardware set, write-one clear, set wins
module uesc_flag_bit (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_set,
  input wire i_clr,
  output reg o_flag
);

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_set) begin
        o_flag <= 1'b1; // [RL23]
      end else if (i_clr) begin
        o_flag <= 1'b0; // [RL23]
      end
    end
  end

endmodule // uesc_flag_bit

// ring pointer that wraps after depth entries
module uesc_ring_ptr #(
  parameter DEPTH = 4,
  parameter PW = 2
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_step,
  output reg [PW-1:0] o_ptr
);

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ptr <= {PW{1'b0}};
    end else if (i_ce & i_step) begin
      if (o_ptr == DEPTH - 1) begin
        o_ptr <= {PW{1'b0}};
      end else begin
        o_ptr <= o_ptr + 1'b1;
      end
    end
  end

endmodule // uesc_ring_ptr
`default_nettype wire

//--- hw/uesc_defines.vh
// register offsets, field positions, reset values and timing counts of the error/status block
`ifndef UESC_DEFINES_VH
`define UESC_DEFINES_VH

`define UESC_OFS_ERR_FLAGS 4'h0
`define UESC_OFS_ERR_EN 4'h4
`define UESC_OFS_STATUS 4'h8
`define UESC_OFS_CONTROL 4'hC

`define UESC_ERR_PID 0
`define UESC_ERR_TOKEN 1
`define UESC_ERR_DATA_CRC 2
`define UESC_ERR_PARTIAL 3
`define UESC_ERR_TURN 4
`define UESC_ERR_MEM 5
`define UESC_ERR_BUSMX 6
`define UESC_ERR_STUFF 7

`define UESC_STAT_EP_LSB 4
`define UESC_STAT_DIR 3
`define UESC_STAT_ODD 2

`define UESC_CON_J_LINE_STATE_SEEN 7
`define UESC_CON_SE0 6
`define UESC_CON_HOLD 5
`define UESC_CON_BUSRST 4
`define UESC_CON_HOST 3
`define UESC_CON_RESUME 2
`define UESC_CON_BANKRST 1
`define UESC_CON_ENABLE 0

`define UESC_RST_BYTE 8'h00
`define UESC_RST_WORD 32'h0000_0000

`define UESC_CLK_MHZ 50
`define UESC_TURN_NS 1334
`define UESC_TURN_CYC ((`UESC_TURN_NS * `UESC_CLK_MHZ + 999) / 1000)
`define UESC_FRAME_US 1000
`define UESC_FRAME_CYC (`UESC_FRAME_US * `UESC_CLK_MHZ)

`endif

//--- verif/uesc_peer.sv
// far-side bus peer model that drives the line levels
`default_nettype none
module uesc_peer (
  input wire logic [1:0] i_mode,
  output logic o_dp,
  output logic o_dm
);
  timeunit 1ns;
  timeprecision 1ps;
  // 0 idle j, 1 se0, 2 k; a full-speed peer idles with dp high
  assign o_dp = i_mode == 2'h0;
  assign o_dm = i_mode == 2'h2;
endmodule // uesc_peer
`default_nettype wire

//--- verif/uesc_chk.sv
// port assertions for the error/status block
`default_nettype none
module uesc_chk (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_ERR_SUM_EN,
  input wire logic I_SETUP_RX,
  input wire logic I_XFER_DONE,
  input wire logic [31:0] O_RDATA,
  input wire logic O_ERR_SUMMARY,
  input wire logic O_IRQ,
  input wire logic O_XFER_DONE,
  input wire logic O_PKT_HOLD,
  input wire logic O_BUS_RESET_DRIVE,
  input wire logic O_HOST_LOGIC_RST,
  input wire logic O_RESUME_DRIVE,
  input wire logic O_LS_EOP,
  input wire logic O_HOST_MODE,
  input wire logic O_SOF_SEND
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_hi; O_RDATA[31:8] == 24'h00_0000; endproperty
  property p_irq; O_IRQ |-> O_ERR_SUMMARY && $past(I_ERR_SUM_EN); endproperty
  property p_brst; O_BUS_RESET_DRIVE |-> O_HOST_MODE; endproperty
  property p_sof; O_SOF_SEND |-> O_HOST_MODE ##1 !O_SOF_SEND; endproperty
  property p_eop; O_LS_EOP |-> O_HOST_MODE && !O_RESUME_DRIVE; endproperty
  property p_hrst; $changed(O_HOST_MODE) |-> $past(O_HOST_LOGIC_RST); endproperty
  property p_hold; I_SETUP_RX && !O_HOST_MODE |=> O_PKT_HOLD; endproperty
  property p_done; I_XFER_DONE |=> O_XFER_DONE; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_irq: assert property (p_irq) else $error("irq without summary");
  a_brst: assert property (p_brst) else $error("bus reset outside host");
  a_sof: assert property (p_sof) else $error("frame marker bad");
  a_eop: assert property (p_eop) else $error("eop bad");
  a_hrst: assert property (p_hrst) else $error("no host reset");
  a_hold: assert property (p_hold) else $error("hold not set");
  a_done: assert property (p_done) else $error("done not set");
  c_irq: cover property (O_IRQ);
  c_eop: cover property (O_LS_EOP);
  c_sof: cover property (O_SOF_SEND);
endmodule // uesc_chk
bind uesc_top uesc_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_ERR_SUM_EN(I_ERR_SUM_EN),
  .I_SETUP_RX(I_SETUP_RX), .I_XFER_DONE(I_XFER_DONE), .O_RDATA(O_RDATA),
  .O_ERR_SUMMARY(O_ERR_SUMMARY), .O_IRQ(O_IRQ), .O_XFER_DONE(O_XFER_DONE),
  .O_PKT_HOLD(O_PKT_HOLD), .O_BUS_RESET_DRIVE(O_BUS_RESET_DRIVE),
  .O_HOST_LOGIC_RST(O_HOST_LOGIC_RST), .O_RESUME_DRIVE(O_RESUME_DRIVE),
  .O_LS_EOP(O_LS_EOP), .O_HOST_MODE(O_HOST_MODE), .O_SOF_SEND(O_SOF_SEND));
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the error/status block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 20;
  localparam int TC = 10;
  // row i: error source ev[i] and the flag it raises
  localparam logic [7:0] FLG [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h20, 8'h40, 8'h80};
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, sum_en = 1, act = 0, tok = 0, tx = 0, odd = 0;
  logic [3:0] addr = '0, ep = '0;
  logic [31:0] wdata = '0;
  logic [12:0] ev = '0;
  logic [1:0] mode = '0;
  wire logic dp, dm;
  wire logic [31:0] rdata;
  wire logic [12:0] o;
  int n_fail = 0, total_checks = 0, n_eop = 0, n_sof = 0, n0;
  uesc_peer peer (.i_mode(mode), .o_dp(dp), .o_dm(dm));
  uesc_top #(.FRAME_CYC(FC), .TURN_CYC(TC)) dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
    .I_DP(dp), .I_DM(dm), .I_PID_FAIL(ev[0]), .I_TOKEN_CRC_FAIL(ev[1]),
    .I_DATA_CRC_FAIL(ev[2]), .I_PARTIAL_BYTE(ev[3]), .I_BUF_TRUNC(ev[4]),
    .I_GRANT_LATE(ev[5]), .I_BUS_MATRIX_FAIL(ev[6]), .I_BIT_STUFF_FAIL(ev[7]),
    .I_EOP_AWAIT(ev[8]), .I_RESP_START(ev[9]), .I_SETUP_RX(ev[10]), .I_XFER_DONE(ev[11]),
    .I_DONE_CLR(ev[12]), .I_XFER_ACTIVE(act), .I_TOKEN_BUSY(tok), .I_XFER_EP(ep),
    .I_XFER_TX(tx), .I_XFER_ODD(odd), .I_ERR_SUM_EN(sum_en), .O_ERR_SUMMARY(o[0]),
    .O_IRQ(o[1]), .O_XFER_DONE(o[2]), .O_STAT_FULL(o[3]), .O_PKT_HOLD(o[4]),
    .O_BUS_RESET_DRIVE(o[5]), .O_HOST_LOGIC_RST(o[6]), .O_RESUME_DRIVE(o[7]),
    .O_LS_EOP(o[8]), .O_BANK_RST(o[9]), .O_MODULE_EN(o[10]), .O_HOST_MODE(o[11]),
    .O_SOF_SEND(o[12]));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    n_eop <= n_eop + o[8];
    n_sof <= n_sof + o[12];
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1;
    addr <= a;
    @(posedge clk);
    rd_s <= 0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(4'h0, '0);
    rd(4'hC, 32'h0000_0080);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, '0);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, 32'h0000_00FF);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rd(4'h0, {24'h00_0000, FLG[i]});
      `CHK(o[1:0], 2'h3)
      wr(4'h0, {24'h00_0000, ~FLG[i]});
      rd(4'h0, {24'h00_0000, FLG[i]});
      wr(4'h0, {24'h00_0000, FLG[i]});
      rd(4'h0, '0);
    end
    wr(4'h4, 32'h0000_0002);
    @(posedge clk) sum_en <= 0;
    pulse(0);
    settle(2);
    `CHK(o[1:0], 2'h0)
    pulse(1);
    settle(2);
    `CHK(o[1:0], 2'h1)
    @(posedge clk) sum_en <= 1;
    settle(2);
    `CHK(o[1:0], 2'h3)
    wr(4'h0, 32'h0000_00FF);
    pulse(8);
    pulse(9);
    settle(TC + 4);
    rd(4'h0, '0);
    pulse(8);
    settle(TC - 4);
    rd(4'h0, '0);
    settle(4);
    rd(4'h0, 32'h0000_0010);
    wr(4'h0, 32'h0000_0010);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      ev[11] <= 1;
      ep <= 4'(15 - 5 * i);
      tx <= i[0];
      odd <= !i[0];
    end
    @(posedge clk) ev <= '0;
    @(negedge clk);
    `CHK(o[3:2], 2'h3)
    for (int i = 0; i < 4; i++) begin
      rd(4'h8, {24'h00_0000, 4'(15 - 5 * i), i[0], !i[0], 2'h0});
      pulse(12);
    end
    settle(2);
    `CHK(o[2], 1'b0)
    @(posedge clk) mode <= 2'h1;
    settle(3);
    rd(4'hC, 32'h0000_0040);
    @(posedge clk) mode <= 2'h2;
    settle(3);
    rd(4'hC, '0);
    @(posedge clk) mode <= 2'h0;
    settle(3);
    pulse(10);
    rd(4'hC, 32'h0000_00A0);
    wr(4'hC, 32'h0000_0003);
    settle(2);
    `CHK(o[10:9], 2'h3)
    `CHK(o[4], 1'b0)
    wr(4'hC, 32'h0000_0007);
    settle(2);
    `CHK(o[7], 1'b1)
    wr(4'hC, 32'h0000_0003);
    settle(4);
    `CHK(n_eop, 0)
    wr(4'hC, 32'h0000_0009);
    settle(2);
    `CHK(o[11:10], 2'h2)
    wr(4'hC, 32'h0000_0019);
    settle(2);
    `CHK(o[5], 1'b1)
    wr(4'hC, 32'h0000_0009);
    settle(2);
    `CHK(o[5], 1'b0)
    @(posedge clk) tok <= 1;
    rd(4'hC, 32'h0000_00A9);
    @(posedge clk) tok <= 0;
    rd(4'hC, 32'h0000_0089);
    pulse(1);
    rd(4'h0, '0);
    wr(4'hC, 32'h0000_000D); // resume held briefly, far shorter than real time
    wr(4'hC, 32'h0000_0009);
    settle(4);
    `CHK(n_eop, 1)
    n0 = n_sof;
    settle(3 * FC);
    `CHK(n_sof - n0, 3)
    @(posedge clk) act <= 1;
    settle(FC + 2);
    rd(4'h0, 32'h0000_0002);
    @(posedge clk) act <= 0;
    wr(4'h0, 32'h0000_00FF);
    wr(4'hC, '0);
    settle(2);
    `CHK(o[11], 1'b0)
    final_report;
  end
endmodule // tb
`default_nettype wire
